// ===== rtl/sswd_pkg.sv
// sswd_pkg: timing constants and state types for the supervisor watchdog
// assumes a 200 MHz timebase feeding the block clock
package sswd_pkg;

    // timebase
    localparam int unsigned CLOCK_KHZ          = 200_000;
    localparam int unsigned CLOCK_MHZ          = 200;
    localparam int unsigned CNT_W              = 32;

    // times in their own units
    localparam int unsigned WD_TIMEOUT_MS      = 1000;
    localparam int unsigned FAULT_PULSE_MS     = 200;
    localparam int unsigned STARTUP_DELAY_MS   = 1000;
    localparam int unsigned RESET_HOLD_MS      = 200;
    localparam int unsigned POWERUP_EXTRA_MS   = 4;
    localparam int unsigned ENABLE_SETTLE_US   = 300;
    localparam int unsigned KICK_MIN_US        = 1;
    localparam int unsigned MANUAL_DELAY_NS    = 250;

    // derived cycle counts
    localparam int unsigned WD_TIMEOUT_CYC     = WD_TIMEOUT_MS * CLOCK_KHZ;
    localparam int unsigned FAULT_PULSE_CYC    = FAULT_PULSE_MS * CLOCK_KHZ;
    localparam int unsigned STARTUP_DELAY_CYC  = STARTUP_DELAY_MS * CLOCK_KHZ;
    localparam int unsigned RESET_HOLD_CYC     = RESET_HOLD_MS * CLOCK_KHZ;
    localparam int unsigned POWERUP_EXTRA_CYC  = POWERUP_EXTRA_MS * CLOCK_KHZ;
    localparam int unsigned ENABLE_SETTLE_CYC  = ENABLE_SETTLE_US * CLOCK_MHZ;
    localparam int unsigned KICK_MIN_CYC       = KICK_MIN_US * CLOCK_MHZ;
    localparam int unsigned MANUAL_DELAY_CYC   = (MANUAL_DELAY_NS * CLOCK_MHZ + 999) / 1000;

    // synchroniser depth and reset values
    localparam int unsigned SYNC_STAGES        = 2;
    localparam logic [4:0]  SYNC_RESET_VALUE   = 5'h03;

    typedef enum logic [1:0] {
        RS_ASSERT = 2'b00,
        RS_HOLD   = 2'b01,
        RS_RUN    = 2'b10
    } sswd_rs_type;

    typedef enum logic [2:0] {
        WD_HALT    = 3'b000,
        WD_STARTUP = 3'b001,
        WD_MONITOR = 3'b010,
        WD_FAULT   = 3'b011
    } sswd_wd_type;

endpackage

// ===== rtl/sswd_sync.sv
// sswd_sync: two-flop synchroniser for a group of pin inputs
// assumes inputs are asynchronous to clock; first stage read only by second
`timescale 1ns/1ps
module sswd_sync
    import sswd_pkg::*;
#(
    parameter int unsigned         WIDTH   = 4,
    parameter logic [WIDTH-1:0]    RST_VAL = '0
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic [WIDTH-1:0]  asyncIn,
    output logic      [WIDTH-1:0]  syncOut
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] stable_q;
    logic [WIDTH-1:0] stable_d;

    always_comb begin
        meta_d   = asyncIn;
        stable_d = meta_q;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_q   <= RST_VAL;
            stable_q <= RST_VAL;
        end else begin
            meta_q   <= meta_d;
            stable_q <= stable_d;
        end
    end

    assign syncOut = stable_q;

endmodule

// ===== rtl/sswd_top.sv
// sswd_top: supply supervisor with system reset and kick watchdog
// assumes 200 MHz timebase, supply comparator output already carries hysteresis
//
// What this block does
// - a kick input held at one level for a whole timeout pulses the fault output low.
// - on expiry the fault output goes low once for the fault pulse width and is released.
// - the watchdog counter restarts when system reset deasserts and on each kick falling edge ending a high pulse of at least 1 us.
// - system reset is held while manual reset is low and for the hold period after.
// - system reset asserts about 250 ns after manual reset goes low.
// - with enable high the watchdog runs; with it low the kick input is ignored.
// - after enable rises, monitoring starts only after a 300 us settling time.
// - supply below threshold asserts reset; once above, reset holds for the hold period.
// - the first power-up after a fast supply rise lengthens the hold period by 4 ms.
// - kick edges are ignored during a fault pulse, during reset and during startup delay.
// - the startup delay starts when reset deasserts; monitoring begins after it.
// - only a kick falling edge ending a high pulse of at least 1 us counts.
`timescale 1ns/1ps
module sswd_top
    import sswd_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = WD_TIMEOUT_CYC,
    parameter int unsigned PULSE_CYCLES   = FAULT_PULSE_CYC,
    parameter int unsigned STARTUP_CYCLES = STARTUP_DELAY_CYC,
    parameter int unsigned HOLD_CYCLES    = RESET_HOLD_CYC,
    parameter int unsigned EXTRA_CYCLES   = POWERUP_EXTRA_CYC,
    parameter int unsigned SETTLE_CYCLES  = ENABLE_SETTLE_CYC
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic supplyLow,
    input  wire logic supplyFastRise,
    input  wire logic manualResetIn_n,
    input  wire logic watchdogEnableIn,
    input  wire logic watchdogKickIn,
    output logic      systemReset_n,
    output logic      systemResetOe,
    output logic      watchdogFault_n,
    output logic      watchdogFaultOe
);

    localparam logic [CNT_W-1:0] TIMEOUT_C = TIMEOUT_CYCLES[CNT_W-1:0];
    localparam logic [CNT_W-1:0] PULSE_C   = PULSE_CYCLES[CNT_W-1:0];
    localparam logic [CNT_W-1:0] STARTUP_C = STARTUP_CYCLES[CNT_W-1:0];
    localparam logic [CNT_W-1:0] HOLD_C    = HOLD_CYCLES[CNT_W-1:0];
    localparam logic [CNT_W-1:0] LONG_C    = HOLD_CYCLES[CNT_W-1:0] + EXTRA_CYCLES[CNT_W-1:0];
    localparam logic [CNT_W-1:0] SETTLE_C  = SETTLE_CYCLES[CNT_W-1:0];
    localparam logic [CNT_W-1:0] KICK_C    = KICK_MIN_CYC[CNT_W-1:0];
    localparam logic [CNT_W-1:0] MRD_C     = MANUAL_DELAY_CYC[CNT_W-1:0];

    // synchronised pins: {fastRise, kick, enable, manual_n, supplyLow}
    logic [4:0] pinSync;
    logic       fastRise;
    logic       supLow;
    logic       manualN;
    logic       enSync;
    logic       kickSync;

    sswd_sync #(
        .WIDTH   (5),
        .RST_VAL (SYNC_RESET_VALUE)
    ) u_sync (
        .clock   (clock),
        .rst     (rst),
        .asyncIn ({supplyFastRise, watchdogKickIn, watchdogEnableIn, manualResetIn_n, supplyLow}),
        .syncOut (pinSync)
    );

    assign supLow   = pinSync[0];
    assign manualN  = pinSync[1];
    assign enSync   = pinSync[2];
    assign kickSync = pinSync[3];
    assign fastRise = pinSync[4];

    // manual reset delay
    logic [CNT_W-1:0] mrCnt_q;
    logic [CNT_W-1:0] mrCnt_d;
    logic             mrActive;

    always_comb begin
        mrCnt_d = '0;
        if (!manualN) begin
            mrCnt_d = (mrCnt_q >= MRD_C) ? mrCnt_q : mrCnt_q + 1'b1;
        end
    end

    assign mrActive = !manualN && (mrCnt_q >= MRD_C);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mrCnt_q <= '0;
        end else begin
            mrCnt_q <= mrCnt_d;
        end
    end

    // system reset sequencer
    sswd_rs_type      rsState_q;
    sswd_rs_type      rsState_d;
    logic [CNT_W-1:0] rsCnt_q;
    logic [CNT_W-1:0] rsCnt_d;
    logic             firstUp_q;
    logic             firstUp_d;
    logic             sysRst_n_q;
    logic             sysRst_n_d;

    always_comb begin
        rsState_d  = rsState_q;
        rsCnt_d    = rsCnt_q;
        firstUp_d  = firstUp_q;
        if (supLow || mrActive) begin
            rsState_d = RS_ASSERT;
            rsCnt_d   = '0;
        end else begin
            unique case (rsState_q)
                RS_ASSERT: begin
                    rsState_d = RS_HOLD;
                    rsCnt_d   = '0;
                end
                RS_HOLD: begin
                    rsCnt_d = rsCnt_q + 1'b1;
                    if (rsCnt_q + 1'b1 >= ((firstUp_q && fastRise) ? LONG_C : HOLD_C)) begin
                        rsState_d = RS_RUN;
                        rsCnt_d   = '0;
                        firstUp_d = 1'b0;
                    end
                end
                RS_RUN: begin
                    rsCnt_d = '0;
                end
                default: begin
                    rsState_d = RS_ASSERT;
                    rsCnt_d   = '0;
                end
            endcase
        end
        sysRst_n_d = (rsState_d == RS_RUN);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rsState_q  <= RS_ASSERT;
            rsCnt_q    <= '0;
            firstUp_q  <= 1'b1;
            sysRst_n_q <= 1'b0;
        end else begin
            rsState_q  <= rsState_d;
            rsCnt_q    <= rsCnt_d;
            firstUp_q  <= firstUp_d;
            sysRst_n_q <= sysRst_n_d;
        end
    end

    // enable settling
    logic [CNT_W-1:0] enCnt_q;
    logic [CNT_W-1:0] enCnt_d;
    logic             enReady;

    always_comb begin
        enCnt_d = '0;
        if (enSync) begin
            enCnt_d = (enCnt_q >= SETTLE_C) ? enCnt_q : enCnt_q + 1'b1;
        end
    end

    assign enReady = enSync && (enCnt_q >= SETTLE_C);

    // kick pulse width qualifier
    logic             kickPrev_q;
    logic             kickPrev_d;
    logic [CNT_W-1:0] kickHigh_q;
    logic [CNT_W-1:0] kickHigh_d;
    logic             kickValid;

    always_comb begin
        kickPrev_d = kickSync;
        kickHigh_d = '0;
        if (kickSync) begin
            kickHigh_d = (kickHigh_q >= KICK_C) ? kickHigh_q : kickHigh_q + 1'b1;
        end
    end

    assign kickValid = kickPrev_q && !kickSync && (kickHigh_q >= KICK_C);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            enCnt_q    <= '0;
            kickPrev_q <= 1'b0;
            kickHigh_q <= '0;
        end else begin
            enCnt_q    <= enCnt_d;
            kickPrev_q <= kickPrev_d;
            kickHigh_q <= kickHigh_d;
        end
    end

    // watchdog sequencer
    sswd_wd_type      wdState_q;
    sswd_wd_type      wdState_d;
    logic [CNT_W-1:0] wdCnt_q;
    logic [CNT_W-1:0] wdCnt_d;
    logic             fault_n_q;
    logic             fault_n_d;

    always_comb begin
        wdState_d = wdState_q;
        wdCnt_d   = wdCnt_q;
        if (!sysRst_n_q) begin
            wdState_d = WD_HALT;
            wdCnt_d   = '0;
        end else begin
            unique case (wdState_q)
                WD_HALT: begin
                    wdState_d = WD_STARTUP;
                    wdCnt_d   = '0;
                end
                WD_STARTUP: begin
                    wdCnt_d = wdCnt_q + 1'b1;
                    if (wdCnt_q + 1'b1 >= STARTUP_C) begin
                        wdState_d = WD_MONITOR;
                        wdCnt_d   = '0;
                    end
                end
                WD_MONITOR: begin
                    if (!enReady || kickValid) begin
                        wdCnt_d = '0;
                    end else if (wdCnt_q + 1'b1 >= TIMEOUT_C) begin
                        wdState_d = WD_FAULT;
                        wdCnt_d   = '0;
                    end else begin
                        wdCnt_d = wdCnt_q + 1'b1;
                    end
                end
                WD_FAULT: begin
                    wdCnt_d = wdCnt_q + 1'b1;
                    if (wdCnt_q + 1'b1 >= PULSE_C) begin
                        wdState_d = WD_MONITOR;
                        wdCnt_d   = '0;
                    end
                end
                default: begin
                    wdState_d = WD_HALT;
                    wdCnt_d   = '0;
                end
            endcase
        end
        fault_n_d = (wdState_d != WD_FAULT);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wdState_q <= WD_HALT;
            wdCnt_q   <= '0;
            fault_n_q <= 1'b1;
        end else begin
            wdState_q <= wdState_d;
            wdCnt_q   <= wdCnt_d;
            fault_n_q <= fault_n_d;
        end
    end

    // open-drain style outputs
    logic rstOe_q;
    logic faultOe_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rstOe_q   <= 1'b1;
            faultOe_q <= 1'b0;
        end else begin
            rstOe_q   <= !sysRst_n_d;
            faultOe_q <= !fault_n_d;
        end
    end

    assign systemReset_n   = sysRst_n_q;
    assign systemResetOe   = rstOe_q;
    assign watchdogFault_n = fault_n_q;
    assign watchdogFaultOe = faultOe_q;

endmodule

// ===== test/sswd_top_sva.sv
// sswd_top_sva: port timing checks for the supervisor watchdog
// assumes binding into sswd_top with its count parameters
`timescale 1ns/1ps
module sswd_top_sva
    import sswd_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = WD_TIMEOUT_CYC,
    parameter int unsigned PULSE_CYCLES   = FAULT_PULSE_CYC,
    parameter int unsigned STARTUP_CYCLES = STARTUP_DELAY_CYC,
    parameter int unsigned HOLD_CYCLES    = RESET_HOLD_CYC,
    parameter int unsigned EXTRA_CYCLES   = POWERUP_EXTRA_CYC,
    parameter int unsigned SETTLE_CYCLES  = ENABLE_SETTLE_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic supplyLow,
    input wire logic supplyFastRise,
    input wire logic manualResetIn_n,
    input wire logic watchdogEnableIn,
    input wire logic watchdogKickIn,
    input wire logic systemReset_n,
    input wire logic systemResetOe,
    input wire logic watchdogFault_n,
    input wire logic watchdogFaultOe
);
    int quietCnt_q, enCnt_q, hiCnt_q, idleCnt_q, lowCnt_q, mrCnt_q, runCnt_q;

    // run lengths of input and output conditions
    always_ff @(posedge clock) begin
        quietCnt_q <= (rst || supplyLow || !manualResetIn_n) ? 0 : quietCnt_q + 1;
        enCnt_q <= (rst || !watchdogEnableIn) ? 0 : enCnt_q + 1;
        hiCnt_q <= (rst || !watchdogKickIn) ? 0 : hiCnt_q + 1;
        idleCnt_q <= (rst || (!watchdogKickIn && hiCnt_q >= KICK_MIN_CYC + 4)) ?
            0 : idleCnt_q + 1;
        lowCnt_q <= (rst || watchdogFault_n) ? 0 : lowCnt_q + 1;
        mrCnt_q <= (rst || manualResetIn_n) ? 0 : mrCnt_q + 1;
        runCnt_q <= (rst || !systemReset_n) ? 0 : runCnt_q + 1;
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_oe_pair: assert property (watchdogFaultOe == !watchdogFault_n
        && systemResetOe == !systemReset_n) else $error("pin enable mismatch");
    a_fault_width: assert property ($rose(watchdogFault_n) && systemReset_n
        |-> lowCnt_q == PULSE_CYCLES) else $error("fault pulse width wrong");
    a_fault_startup: assert property ($fell(watchdogFault_n)
        |-> runCnt_q >= STARTUP_CYCLES + TIMEOUT_CYCLES) else $error("fault too soon");
    a_fault_settled: assert property ($fell(watchdogFault_n)
        |-> enCnt_q >= SETTLE_CYCLES + TIMEOUT_CYCLES) else $error("fault before settle");
    a_fault_idle: assert property ($fell(watchdogFault_n)
        |-> idleCnt_q >= TIMEOUT_CYCLES) else $error("fault despite kick");
    a_supply_trip: assert property (supplyLow |-> ##[1:5] !systemReset_n)
        else $error("supply low without reset");
    a_hold_min: assert property ($rose(systemReset_n)
        |-> quietCnt_q >= HOLD_CYCLES) else $error("reset released early");
    a_hold_max: assert property (quietCnt_q == HOLD_CYCLES + EXTRA_CYCLES + 8
        |-> systemReset_n) else $error("reset held too long");
    a_manual_trip: assert property (mrCnt_q == 56 |-> !systemReset_n)
        else $error("manual reset not taken");

    c_fault: cover property ($fell(watchdogFault_n));
    c_glitch: cover property (mrCnt_q == 30 && systemReset_n);
    c_supply: cover property ($rose(supplyLow));
endmodule

bind sswd_top sswd_top_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES), .PULSE_CYCLES(PULSE_CYCLES),
    .STARTUP_CYCLES(STARTUP_CYCLES), .HOLD_CYCLES(HOLD_CYCLES), .EXTRA_CYCLES(EXTRA_CYCLES),
    .SETTLE_CYCLES(SETTLE_CYCLES)) sva_i (.clock, .rst, .supplyLow, .supplyFastRise,
    .manualResetIn_n, .watchdogEnableIn, .watchdogKickIn, .systemReset_n, .systemResetOe,
    .watchdogFault_n, .watchdogFaultOe);

// ===== test/sswd_host_model.sv
// sswd_host_model: host processor kicking the watchdog pin
// assumes gating by run; idles low while held in reset
`timescale 1ns/1ps
module sswd_host_model (
    input  wire logic clock,
    input  wire logic run,
    input  wire logic shortPulse,
    input  wire logic systemReset_n,
    output logic      kick
);
    int phase_q;

    initial begin
        kick = 1'h0;
        phase_q = 0;
    end

    // high 220 cycles, low 100; short mode gives too narrow pulses
    always @(posedge clock) begin
        if (!run || !systemReset_n) begin
            kick <= #1 1'h0;
            phase_q <= 0;
        end else begin
            phase_q <= (phase_q == 319) ? 0 : phase_q + 1;
            kick <= #1 (phase_q < (shortPulse ? 50 : 220));
        end
    end
endmodule

// ===== test/sswd_top_tb.sv
// sswd_top_tb: directed timing scenarios for the supervisor watchdog
// assumes shortened counts and the host model on the kick pin
`timescale 1ns/1ps
module sswd_top_tb;
    localparam int TO = 500;
    localparam int PW = 50;
    localparam int SU = 100;
    localparam int HO = 100;
    localparam int EX = 40;
    localparam int ST = 60;
    logic clock, rst, supplyLow, supplyFastRise, manualResetIn_n;
    logic watchdogEnableIn, watchdogKickIn, run, shortPulse;
    logic systemReset_n, systemResetOe, watchdogFault_n, watchdogFaultOe;
    int   num_errors, checks;

    sswd_top #(.TIMEOUT_CYCLES(TO), .PULSE_CYCLES(PW), .STARTUP_CYCLES(SU),
        .HOLD_CYCLES(HO), .EXTRA_CYCLES(EX), .SETTLE_CYCLES(ST)) dut (.clock, .rst,
        .supplyLow, .supplyFastRise, .manualResetIn_n, .watchdogEnableIn, .watchdogKickIn,
        .systemReset_n, .systemResetOe, .watchdogFault_n, .watchdogFaultOe);
    sswd_host_model host (.clock, .run, .shortPulse, .systemReset_n,
        .kick(watchdogKickIn));

    initial begin
        clock = 1'h0;
        forever #2.5 clock = ~clock;
    end

    // waits for reset (0) or fault (1) to reach v, then checks the count
    task automatic wait_on(input bit which, input logic v, input int lim, lo, hi);
        int n;
        n = 0;
        while ((which ? watchdogFault_n : systemReset_n) !== v && n < lim) begin
            @(posedge clock);
            #1;
            n++;
        end
        checks++;
        if (n < lo || n > hi || $isunknown({systemReset_n, watchdogFault_n})) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, n, lo, hi);
        end
        checks++;
        if ({systemResetOe, watchdogFaultOe} !== ~{systemReset_n, watchdogFault_n}) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, {systemResetOe, watchdogFaultOe},
                ~{systemReset_n, watchdogFault_n});
        end
    endtask

    // mid-run reset with a slow supply rise: no extra hold time
    task automatic t_rerun;
        rst = 1'h1;
        supplyFastRise = 1'h0;
        repeat (4) @(posedge clock);
        #1;
        wait_on(0, 1'h0, 1, 0, 0);
        wait_on(1, 1'h1, 1, 0, 0);
        rst = 1'h0;
        wait_on(0, 1'h1, 300, HO, HO + 6);
    endtask

    task automatic t_powerup;
        wait_on(0, 1'h1, 400, HO + EX, HO + EX + 8);
    endtask

    task automatic t_kick;
        watchdogEnableIn = 1'h1;
        run = 1'h1;
        wait_on(1, 1'h0, 3000, 3000, 3000);
        run = 1'h0;
        wait_on(1, 1'h0, 700, TO - 330, TO + 4);
        wait_on(1, 1'h1, 200, PW - 1, PW + 1);
        wait_on(1, 1'h0, 700, TO - 3, TO + 3);
        wait_on(1, 1'h1, 200, PW - 1, PW + 1);
    endtask

    task automatic t_short;
        shortPulse = 1'h1;
        run = 1'h1;
        wait_on(1, 1'h0, 700, TO - 3, TO + 3);
        wait_on(1, 1'h1, 200, PW - 1, PW + 1);
    endtask

    task automatic t_enable;
        watchdogEnableIn = 1'h0;
        wait_on(1, 1'h0, 1500, 1500, 1500);
        run = 1'h0;
        shortPulse = 1'h0;
        watchdogEnableIn = 1'h1;
        wait_on(1, 1'h0, 800, ST + TO - 2, ST + TO + 6);
        wait_on(1, 1'h1, 200, PW - 1, PW + 1);
    endtask

    task automatic t_manual;
        manualResetIn_n = 1'h0;
        wait_on(0, 1'h0, 30, 30, 30);
        manualResetIn_n = 1'h1;
        wait_on(0, 1'h0, 40, 40, 40);
        manualResetIn_n = 1'h0;
        wait_on(0, 1'h0, 80, 50, 56);
        wait_on(0, 1'h1, 200, 200, 200);
        manualResetIn_n = 1'h1;
        wait_on(0, 1'h1, 300, HO, HO + 6);
    endtask

    task automatic t_supply;
        supplyLow = 1'h1;
        wait_on(0, 1'h0, 10, 1, 5);
        wait_on(0, 1'h1, 50, 50, 50);
        supplyLow = 1'h0;
        wait_on(0, 1'h1, 300, HO, HO + 6);
        wait_on(1, 1'h0, 900, SU + TO - 3, SU + ST + TO + 8);
        wait_on(1, 1'h1, 200, PW - 1, PW + 1);
    endtask

    task automatic close_out;
        $display("checks=%0d errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        rst = 1'h1;
        supplyLow = 1'h0;
        supplyFastRise = 1'h1;
        manualResetIn_n = 1'h1;
        watchdogEnableIn = 1'h0;
        run = 1'h0;
        shortPulse = 1'h0;
        num_errors = 0;
        checks = 0;
        repeat (20) @(posedge clock);
        #1;
        rst = 1'h0;
        t_powerup;
        t_kick;
        t_short;
        t_enable;
        t_manual;
        t_supply;
        t_rerun;
        close_out;
    end

    initial begin
        #200000;
        num_errors++;
        close_out;
    end
endmodule
